// [design/node_pkg.sv]
// Constants, field layouts and helpers shared by the memory node files.
package node_pkg;
  // ----------------------------------------
  // Register word indexes (byte address = 4 * index).
  // ----------------------------------------
  localparam logic [3:0] ID_IDX    = 4'h2;
  localparam logic [3:0] PART_IDX  = 4'h3;
  localparam logic [3:0] CMD_IDX   = 4'h4;
  localparam logic [3:0] STATE_IDX = 4'h6;
  // ----------------------------------------
  // Identity register fields.
  // ----------------------------------------
  localparam int ID_MOD_LSB = 0;
  localparam int ID_PAR_BIT = 6;
  localparam int ID_BUS_LSB = 7;
  localparam int ID_KND_LSB = 10;
  // ----------------------------------------
  // State register fields.
  // ----------------------------------------
  localparam int ST_BUS_LSB = 0;
  localparam int ST_MAR_BIT = 4;
  localparam int ST_SHS_BIT = 5;
  localparam int ST_ILV_BIT = 6;
  localparam int ST_FRC_BIT = 7;
  localparam int ST_WRM_BIT = 8;
  localparam int ST_ROL_BIT = 9;
  // ----------------------------------------
  // Command register fields.
  // ----------------------------------------
  localparam int CMD_TOG_BIT = 0;
  localparam int CMD_INI_BIT = 1;
  localparam int CMD_RTY_BIT = 2;
  // ----------------------------------------
  // Strap line positions.
  // ----------------------------------------
  localparam int STRAP_ID_LSB  = 1;
  localparam int STRAP_PAR_BIT = 7;
  localparam int STRAP_RED_BIT = 12;
  localparam int WARM_LINE     = 11;
  // ----------------------------------------
  // Reset values and codes.
  // ----------------------------------------
  localparam logic [5:0] PART_RST  = 6'h00;
  localparam logic [3:0] BS_NULL   = 4'h0;
  localparam logic [1:0] KIND_LIN  = 2'h0;
  localparam logic [1:0] KIND_64K  = 2'h1;
  localparam logic [1:0] KIND_16K  = 2'h2;
  localparam int         ADR_W     = 20;
  localparam int         DAT_W     = 32;

  // Even parity check over a code and its parity bit.
  function automatic logic par_even(input logic [5:0] code, input logic p);
    par_even = ~(^{code, p});
  endfunction
endpackage

// [design/addr_map.sv]
// Places memory-bus address bits onto strap bus positions by RAM kind.
module addr_map
  import node_pkg::*;
(
  input  wire logic [1:0]       ram_kind_code_i,
  input  wire logic [ADR_W-1:0] mem_addr_i,
  output logic      [ADR_W-1:0] strap_addr_o
);
  always_comb begin
    unique case (ram_kind_code_i)
      KIND_16K: begin // [RQ1]
        strap_addr_o = {mem_addr_i[15], mem_addr_i[14], mem_addr_i[19], mem_addr_i[17],
                        mem_addr_i[13:7], mem_addr_i[18], mem_addr_i[16], mem_addr_i[6:0]};
      end
      KIND_64K: begin // [RQ1]
        strap_addr_o = {mem_addr_i[17], mem_addr_i[16], mem_addr_i[19], mem_addr_i[15:8],
                        mem_addr_i[18], mem_addr_i[7:0]};
      end
      default: begin // [RQ1]
        strap_addr_o = mem_addr_i;
      end
    endcase
  end
endmodule

// [design/bus_state_decode.sv]
// Decodes the four-bit bus state code into state number and bus choice.
module bus_state_decode
  import node_pkg::*;
(
  input  wire logic [3:0] code_i,
  output logic            valid_o,
  output logic            backup_o,
  output logic [2:0]      index_o
);
  always_comb begin
    valid_o  = 1'b1;
    backup_o = 1'b0;
    unique case (code_i) // [RQ15]
      4'h0: index_o = 3'h0;
      4'h1: index_o = 3'h1;
      4'h4: begin
        index_o  = 3'h2;
        backup_o = 1'b1; // [RQ16]
      end
      4'h5: index_o = 3'h3;
      4'hA: begin
        index_o  = 3'h4;
        backup_o = 1'b1; // [RQ16]
      end
      4'hC: begin
        index_o  = 3'h5;
        backup_o = 1'b1; // [RQ16]
      end
      4'h3: index_o = 3'h6;
      default: begin
        index_o = 3'h0;
        valid_o = 1'b0;
      end
    endcase
  end
endmodule

// [design/mem_node.sv]
// Identity, pairing and bus-state register bank of a memory node.
// How it works
// [RQ1] Memory address bits go onto strap lines 19..0 permuted by RAM kind.
// [RQ2] Node position code is taken from strap lines 6..1 at first load.
// [RQ3] Node position code is read-only and gates register access participation.
// [RQ4] Strap line 7 is identity parity; odd parity holds internal init forever.
// [RQ5] Buffer check toggle stops while internal init is held.
// [RQ6] Backup bus is home code with middle bit inverted; a command flips it.
// [RQ7] Home bus code keeps showing the normal bus while on backup.
// [RQ8] Bus select output follows home middle bit and bus state.
// [RQ9] Partner code resets to zero.
// [RQ10] Software writes partner code before pairing, then leaves it alone.
// [RQ11] Permanent module error from partner clears paired bit, node takes over.
// [RQ12] Shadow select fixes shadow or primary role when pairing starts.
// [RQ13] Bus state: normal, backup, mirrored normal, mirrored backup enables.
// [RQ14] Both normal enables load from strap line 12 at first load.
// [RQ15] Only seven bus state codes are accepted.
// [RQ16] States 2, 4 and 5 use the backup bus, others the normal bus.
// [RQ17] Null state ignores memory accesses but answers register accesses.
// [RQ18] Forced staging corrects data before returning it.
// [RQ19] Without forced staging data returns early, staged on retry after error.
// [RQ20] The requester buffers early data until any error report passes.
// [RQ21] Warm/cold flag latched from memory line 11; warm keeps preserved state.
module mem_node
  import node_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [5:0]       adr_i,
  input  wire logic [DAT_W-1:0] dat_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             we_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  input  wire logic             first_load_phase_i,
  input  wire logic [4:0]       cfg_strap_i,
  input  wire logic             memory_link_line_i,
  input  wire logic [ADR_W-1:0] local_strap_bus_i,
  output logic      [ADR_W-1:0] local_strap_bus_o,
  output logic                  local_strap_bus_oe_n_o,
  input  wire logic             mem_req_i,
  input  wire logic [ADR_W-1:0] mem_addr_i,
  output logic                  mem_accept_o,
  output logic                  stage_o,
  input  wire logic             err_valid_i,
  input  wire logic [5:0]       err_module_i,
  input  wire logic             err_perm_i,
  input  wire logic             err_is_module_i,
  input  wire logic             ic_sel_i,
  input  wire logic [5:0]       ic_module_i,
  output logic                  ic_take_o,
  output logic                  buffer_check_toggle_o,
  output logic                  bus_select_out_o,
  output logic                  married_o,
  output logic                  shadow_o,
  output logic                  warm_keep_o,
  output logic                  init_held_o
);
  // ----------------------------------------
  // State.
  // ----------------------------------------
  typedef struct packed {
    logic [ADR_W-1:0] strap1;
    logic [ADR_W-1:0] strap2;
    logic [4:0]       cfg1;
    logic [4:0]       cfg2;
    logic             ph1;
    logic             ph2;
    logic             ph_d;
    logic             wl1;
    logic             wl2;
    logic             init;
    logic [5:0]       node_identity;
    logic             id_par;
    logic [2:0]       bus_id;
    logic [1:0]       kind;
    logic [5:0]       partner;
    logic [3:0]       bstate;
    logic             married;
    logic             shadow_sel;
    logic             role;
    logic             ilv;
    logic             forced;
    logic             warm;
    logic             retry;
    logic             buf_tog;
    logic             bus_sel;
    logic [ADR_W-1:0] strap_o;
    logic             strap_oe_n;
    logic             accept;
    logic             stage;
    logic             take;
    logic             ack;
    logic [15:0]      rdata;
  } node_s;

  node_s st_reg;
  node_s st_next;

  logic [ADR_W-1:0] mapped;
  logic             bs_valid;
  logic             bs_backup;
  logic [2:0]       bs_index;
  logic             wr_valid;
  logic             wr_backup;
  logic [2:0]       wr_index;
  logic             req;
  logic             wr;
  logic [3:0]       idx;
  logic             load;
  logic             divorce;

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  addr_map u_map (
    .ram_kind_code_i (st_reg.kind),
    .mem_addr_i      (mem_addr_i),
    .strap_addr_o    (mapped)
  );

  bus_state_decode u_cur (
    .code_i   (st_reg.bstate),
    .valid_o  (bs_valid),
    .backup_o (bs_backup),
    .index_o  (bs_index)
  );

  bus_state_decode u_wr (
    .code_i   (dat_i[ST_BUS_LSB +: 4]),
    .valid_o  (wr_valid),
    .backup_o (wr_backup),
    .index_o  (wr_index)
  );

  assign req     = cyc_i & stb_i & ~st_reg.ack;
  assign wr      = cyc_i & stb_i & st_reg.ack & we_i & sel_i[0];
  assign idx     = adr_i[5:2];
  assign load    = st_reg.ph2 & ~st_reg.ph_d;
  assign divorce = err_valid_i & err_perm_i & err_is_module_i
                   & (err_module_i == st_reg.partner);

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.strap1 = local_strap_bus_i;
    st_next.strap2 = st_reg.strap1;
    st_next.cfg1   = cfg_strap_i;
    st_next.cfg2   = st_reg.cfg1;
    st_next.ph1    = first_load_phase_i;
    st_next.ph2    = st_reg.ph1;
    st_next.ph_d   = st_reg.ph2;
    st_next.wl1    = memory_link_line_i;
    st_next.wl2    = st_reg.wl1;
    st_next.ack    = req;
    st_next.rdata  = 16'h0000;

    if (load) begin
      st_next.node_identity = st_reg.strap2[STRAP_ID_LSB +: 6]; // [RQ2]
      st_next.id_par    = st_reg.strap2[STRAP_PAR_BIT];
      st_next.bstate    = {1'b0, st_reg.strap2[STRAP_RED_BIT],
                           1'b0, st_reg.strap2[STRAP_RED_BIT]}; // [RQ14]
      st_next.bus_id    = st_reg.cfg2[4:2];
      st_next.kind      = st_reg.cfg2[1:0];
      st_next.warm      = st_reg.wl2; // [RQ21]
      st_next.init      = ~par_even(st_reg.strap2[STRAP_ID_LSB +: 6],
                                    st_reg.strap2[STRAP_PAR_BIT]); // [RQ4]
    end

    if (wr && idx == PART_IDX) begin
      st_next.partner = dat_i[5:0];
    end
    if (wr && idx == CMD_IDX && dat_i[CMD_TOG_BIT]) begin
      st_next.bus_id[1] = ~st_reg.bus_id[1]; // [RQ6]
    end
    if (wr && idx == STATE_IDX) begin
      if (wr_valid) begin
        st_next.bstate = dat_i[ST_BUS_LSB +: 4]; // [RQ15]
      end
      st_next.married    = dat_i[ST_MAR_BIT];
      st_next.shadow_sel = dat_i[ST_SHS_BIT];
      st_next.ilv        = dat_i[ST_ILV_BIT];
      st_next.forced     = dat_i[ST_FRC_BIT];
    end
    if (st_next.married && !st_reg.married) begin
      st_next.role = st_next.shadow_sel; // [RQ12]
    end
    if (divorce) begin
      st_next.married = 1'b0; // [RQ11]
      st_next.role    = 1'b0; // [RQ11]
    end

    if (req && !we_i) begin
      unique case (idx)
        ID_IDX: begin
          st_next.rdata = {4'h0, st_reg.kind, st_reg.bus_id, // [RQ7]
                           st_reg.id_par, st_reg.node_identity};
        end
        PART_IDX: begin
          st_next.rdata = {10'h000, st_reg.partner};
        end
        CMD_IDX: begin
          st_next.rdata = {13'h0000, st_reg.retry, st_reg.init, 1'b0};
        end
        STATE_IDX: begin
          st_next.rdata = {6'h00, st_reg.role, st_reg.warm, st_reg.forced,
                           st_reg.ilv, st_reg.shadow_sel, st_reg.married,
                           st_reg.bstate}; // [RQ13]
        end
        default: begin
          st_next.rdata = 16'h0000;
        end
      endcase
    end

    st_next.take = ic_sel_i & ~st_reg.init & (ic_module_i == st_reg.node_identity); // [RQ3]

    if (!st_reg.init) begin
      st_next.buf_tog = ~st_reg.buf_tog; // [RQ5]
    end
    st_next.bus_sel = st_reg.bus_id[1] ^ bs_backup; // [RQ8] [RQ16]

    st_next.accept     = mem_req_i & ~st_reg.init & bs_valid
                         & (st_reg.bstate != BS_NULL); // [RQ17]
    st_next.strap_oe_n = ~st_next.accept;
    st_next.strap_o    = st_next.accept ? mapped : st_reg.strap_o; // [RQ1]
    st_next.stage      = st_next.accept & (st_reg.forced | st_reg.retry); // [RQ18] [RQ19]
    if (st_next.accept) begin
      st_next.retry = 1'b0;
    end
    if (err_valid_i && !st_reg.forced) begin
      st_next.retry = 1'b1; // [RQ19]
    end
  end

  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg            <= '0;
      st_reg.init       <= 1'b1;
      st_reg.partner    <= PART_RST; // [RQ9]
      st_reg.strap_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dat_o                  = {16'h0000, st_reg.rdata};
  assign ack_o                  = st_reg.ack;
  assign local_strap_bus_o      = st_reg.strap_o;
  assign local_strap_bus_oe_n_o = st_reg.strap_oe_n;
  assign mem_accept_o           = st_reg.accept;
  assign stage_o                = st_reg.stage;
  assign ic_take_o              = st_reg.take;
  assign buffer_check_toggle_o  = st_reg.buf_tog;
  assign bus_select_out_o       = st_reg.bus_sel;
  assign married_o              = st_reg.married;
  assign shadow_o               = st_reg.role;
  assign warm_keep_o            = st_reg.warm;
  assign init_held_o            = st_reg.init;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_id_ro;
    wr && idx == ID_IDX && !load |=> $stable(st_reg.node_identity);
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("id changed by write"); // [RQ3]

  property p_par;
    load && !par_even(st_reg.strap2[STRAP_ID_LSB +: 6], st_reg.strap2[STRAP_PAR_BIT])
      |=> init_held_o [*4];
  endproperty
  a_par: assert property (p_par) else $error("bad parity did not hold init"); // [RQ4]

  property p_buf;
    init_held_o |=> $stable(buffer_check_toggle_o);
  endproperty
  a_buf: assert property (p_buf) else $error("toggle moved in init"); // [RQ5]

  property p_bus_select_out;
    ##1 bus_select_out_o == ($past(st_reg.bus_id[1])
                             ^ $past(st_reg.bstate == 4'h4 || st_reg.bstate == 4'hA
                                     || st_reg.bstate == 4'hC));
  endproperty
  a_bus_select_out: assert property (p_bus_select_out) else $error("bus select wrong"); // [RQ8]

  property p_divorce;
    divorce |=> !married_o && !shadow_o;
  endproperty
  a_divorce: assert property (p_divorce) else $error("no divorce"); // [RQ11]

  property p_role;
    $rose(married_o) |-> shadow_o == st_reg.shadow_sel;
  endproperty
  a_role: assert property (p_role) else $error("role not taken"); // [RQ12]

  property p_null;
    st_reg.bstate == BS_NULL |=> !mem_accept_o;
  endproperty
  a_null: assert property (p_null) else $error("null state accepted"); // [RQ17]

  property p_forced;
    st_reg.forced && mem_req_i && !init_held_o && st_reg.bstate != BS_NULL |=> stage_o;
  endproperty
  a_forced: assert property (p_forced) else $error("forced read not staged"); // [RQ18]

  property p_valid;
    bs_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("illegal bus state"); // [RQ15]

  property p_ack;
    req |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
endmodule

// [verif/switch_model.sv]
// Bus switch model that requests memory, reports errors and selects nodes.
module switch_model
  import node_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             accept_i,
  input  wire logic             stage_i,
  input  wire logic             take_i,
  output logic                  req_o,
  output logic      [ADR_W-1:0] addr_o,
  output logic                  err_o,
  output logic      [5:0]       mod_o,
  output logic                  perm_o,
  output logic                  is_mod_o,
  output logic                  ic_o,
  output logic      [5:0]       ic_mod_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_o, addr_o, err_o, mod_o, perm_o, is_mod_o, ic_o, ic_mod_o} = '0;
  // Drives a one-cycle memory request, then samples the accept and staging flags.
  task automatic access(input logic [ADR_W-1:0] a, output logic acc, output logic stg);
    @(posedge clk_i);
    req_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    req_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    acc = accept_i;
    stg = stage_i;
  endtask
  task automatic report(input logic [5:0] m, input logic p, input logic im);
    @(posedge clk_i);
    {err_o, mod_o, perm_o, is_mod_o} <= {1'b1, m, p, im};
    @(posedge clk_i);
    {err_o, mod_o, perm_o, is_mod_o} <= {1'b0, ~m, ~p, ~im};
  endtask
  task automatic select(input logic [5:0] m, output logic tk);
    @(posedge clk_i);
    {ic_o, ic_mod_o} <= {1'b1, m};
    @(posedge clk_i);
    {ic_o, ic_mod_o} <= {1'b0, ~m};
    @(posedge clk_i);
    tk = take_i;
  endtask
endmodule

// [verif/tb_mem_node.sv]
// Self-checking testbench for the memory node register bank.
module tb_mem_node;
  timeunit 1ns;
  timeprecision 1ps;
  import node_pkg::*;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, first_load_phase_i, memory_link_line_i;
  logic mem_req_i, mem_accept_o, stage_o, err_valid_i, err_perm_i, err_is_module_i, ic_sel_i;
  logic ic_take_o, buffer_check_toggle_o, bus_select_out_o, married_o, shadow_o, warm_keep_o;
  logic init_held_o, local_strap_bus_oe_n_o, acc, stg, tk;
  logic [5:0] adr_i, err_module_i, ic_module_i;
  logic [3:0] sel_i;
  logic [4:0] cfg_strap_i;
  logic [31:0] dat_i, dat_o, r;
  logic [19:0] local_strap_bus_i, local_strap_bus_o, mem_addr_i;
  int num_errors = 0;
  int check_count = 0;
  int map2 [20] = '{15, 14, 19, 17, 13, 12, 11, 10, 9, 8, 7, 18, 16, 6, 5, 4, 3, 2, 1, 0};
  int map1 [20] = '{17, 16, 19, 15, 14, 13, 12, 11, 10, 9, 8, 18, 7, 6, 5, 4, 3, 2, 1, 0};

  mem_node mem_node_i (
    .clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .first_load_phase_i, .cfg_strap_i, .memory_link_line_i, .local_strap_bus_i,
    .local_strap_bus_o, .local_strap_bus_oe_n_o, .mem_req_i, .mem_addr_i, .mem_accept_o,
    .stage_o, .err_valid_i, .err_module_i, .err_perm_i, .err_is_module_i, .ic_sel_i,
    .ic_module_i, .ic_take_o, .buffer_check_toggle_o, .bus_select_out_o, .married_o,
    .shadow_o, .warm_keep_o, .init_held_o
  );
  switch_model switch_model_i (
    .clk_i, .accept_i(mem_accept_o), .stage_i(stage_o), .take_i(ic_take_o),
    .req_o(mem_req_i), .addr_o(mem_addr_i), .err_o(err_valid_i), .mod_o(err_module_i),
    .perm_o(err_perm_i), .is_mod_o(err_is_module_i), .ic_o(ic_sel_i), .ic_mod_o(ic_module_i)
  );

  always #5 clk_i = ~clk_i;

  // ----------------------------------------
  // Shared helpers.
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, 16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk(32'(ack_o), 32'h1);
    r = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 16'h0000);
    chk(r, e);
  endtask
  function automatic logic [19:0] mapped(input logic [1:0] k, input logic [19:0] a);
    for (int i = 0; i < 20; i++) begin
      mapped[19-i] = (k == KIND_16K) ? a[map2[i]] : (k == KIND_64K) ? a[map1[i]] : a[19-i];
    end
  endfunction
  task automatic toggles(input logic run);
    logic b;
    @(posedge clk_i);
    b = buffer_check_toggle_o;
    @(posedge clk_i);
    chk(32'(b ^ buffer_check_toggle_o), 32'(run));
  endtask
  task automatic load(input logic [1:0] k, input logic p);
    int n;
    n = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    local_strap_bus_i <= {7'h00, k != 2'h0, 4'h0, p, 6'h2C, 1'b0};
    cfg_strap_i <= {3'b010, k};
    memory_link_line_i <= k[0];
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    first_load_phase_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (init_held_o !== 1'b0 && n < 12);
    first_load_phase_i <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_init(input logic [1:0] k);
    load(k, 1'b1);
    chk(32'(init_held_o), 32'h0);
    rdc(ID_IDX, {20'h0, k, 3'b010, 1'b1, 6'h2C});
    rdc(STATE_IDX, {23'h0, k[0], 4'h0, (k != 2'h0) ? 4'h5 : 4'h0});
    chk(32'(warm_keep_o), 32'(k[0]));
    toggles(1'b1);
    wb(1'b1, STATE_IDX, 16'h0001);
    switch_model_i.access(20'hB3C5A, acc, stg);
    chk({acc, ~local_strap_bus_oe_n_o, local_strap_bus_o}, {2'b11, mapped(k, 20'hB3C5A)});
    $display("init kind %0d done", k);
  endtask
  task automatic t_id;
    wb(1'b1, ID_IDX, 16'hFFFF);
    rdc(ID_IDX, {20'h0, 2'h2, 3'b010, 1'b1, 6'h2C});
    switch_model_i.select(6'h2C, tk);
    chk(32'(tk), 32'h1);
    switch_model_i.select(6'h2D, tk);
    chk(32'(tk), 32'h0);
    rdc(PART_IDX, 32'h0);
    rdc(4'hF, 32'h0);
    $display("identity done");
  endtask
  task automatic t_states;
    logic [3:0] e;
    for (int c = 0; c < 16; c++) begin
      wb(1'b1, STATE_IDX, 16'h0001);
      wb(1'b1, STATE_IDX, 16'(c));
      e = (c inside {0, 1, 3, 4, 5, 10, 12}) ? 4'(c) : 4'h1;
      rdc(STATE_IDX, {28'h0, e});
      chk(32'(bus_select_out_o), 32'(!(e inside {4'h4, 4'hA, 4'hC})));
    end
    wb(1'b1, STATE_IDX, 16'h0000);
    switch_model_i.access(20'h12345, acc, stg);
    chk(32'(acc), 32'h0);
    rdc(STATE_IDX, 32'h0);
    wb(1'b1, STATE_IDX, 16'h0001);
    wb(1'b1, CMD_IDX, 16'h0001);
    rdc(ID_IDX, {20'h0, 2'h2, 3'b000, 1'b1, 6'h2C});
    chk(32'(bus_select_out_o), 32'h0);
    wb(1'b1, STATE_IDX, 16'h0004);
    rdc(ID_IDX, {20'h0, 2'h2, 3'b000, 1'b1, 6'h2C});
    chk(32'(bus_select_out_o), 32'h1);
    wb(1'b1, CMD_IDX, 16'h0001);
    $display("bus states done");
  endtask
  task automatic t_pair;
    wb(1'b1, STATE_IDX, 16'h0001);
    wb(1'b1, PART_IDX, 16'h0015);
    rdc(PART_IDX, 32'h15);
    wb(1'b1, STATE_IDX, 16'h0031);
    rdc(STATE_IDX, 32'h0231);
    chk(32'({married_o, shadow_o}), 32'h3);
    switch_model_i.report(6'h16, 1'b1, 1'b1);
    switch_model_i.report(6'h15, 1'b0, 1'b1);
    switch_model_i.report(6'h15, 1'b1, 1'b0);
    @(posedge clk_i);
    chk(32'(married_o), 32'h1);
    switch_model_i.report(6'h15, 1'b1, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(32'({married_o, shadow_o}), 32'h0);
    wb(1'b1, STATE_IDX, 16'h0011);
    rdc(STATE_IDX, 32'h0011);
    chk(32'({married_o, shadow_o}), 32'h2);
    $display("pairing done");
  endtask
  task automatic t_stage;
    wb(1'b1, STATE_IDX, 16'h0001);
    switch_model_i.access(20'h00401, acc, stg);
    chk(32'({acc, stg}), 32'h3);
    wb(1'b1, STATE_IDX, 16'h0081);
    switch_model_i.access(20'h00400, acc, stg);
    chk(32'({acc, stg}), 32'h3);
    wb(1'b1, STATE_IDX, 16'h0001);
    switch_model_i.access(20'h00402, acc, stg);
    chk(32'({acc, stg}), 32'h2);
    switch_model_i.report(6'h01, 1'b0, 1'b0);
    switch_model_i.access(20'h00403, acc, stg);
    chk(32'({acc, stg}), 32'h3);
    switch_model_i.access(20'h00404, acc, stg);
    chk(32'(stg), 32'h0);
    $display("staging done");
  endtask
  task automatic t_badpar;
    load(2'h1, 1'b0);
    chk(32'(init_held_o), 32'h1);
    toggles(1'b0);
    switch_model_i.access(20'h00404, acc, stg);
    chk(32'(acc), 32'h0);
    switch_model_i.select(6'h2C, tk);
    chk(32'(tk), 32'h0);
    $display("bad parity done");
  endtask

  // ----------------------------------------
  // Run control.
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report;
  end
  initial begin
    {clk_i, rst_i, we_i, cyc_i, stb_i, first_load_phase_i, memory_link_line_i} = 7'b0100000;
    {adr_i, dat_i, cfg_strap_i, local_strap_bus_i} = '0;
    sel_i = 4'hF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 3; k < 7; k++) begin
      t_init(2'(k));
    end
    t_id;
    t_states;
    t_pair;
    t_stage;
    t_badpar;
    final_report;
  end
endmodule
